// ### design/tal_phy.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tal_phy import tal_pkg::*; #(
  parameter int unsigned LOSS_CYC = LOSS_MS * (1000000 / CLK_NS),
  parameter int unsigned SEP_MIN_CYC = SEP_MIN_US * (1000 / CLK_NS),
  parameter int unsigned SEP_MAX_CYC = SEP_MAX_MS * (1000000 / CLK_NS),
  parameter int unsigned LP_PER_CYC = LP_PER_MS * (1000000 / CLK_NS),
  parameter int unsigned LOCK_BITS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_data_in,
  input wire logic transmit_enable_in,
  input wire logic full_duplex_select,
  input wire logic tp_receive_pair_pos,
  input wire logic tp_receive_pair_neg,
  input wire logic aui_receive_pair_pos,
  input wire logic aui_receive_pair_neg,
  input wire logic aui_collision_pair_pos,
  input wire logic aui_collision_pair_neg,
  output logic transmit_bit_clock,
  output logic rx_data_out,
  output logic rx_clock_out,
  output logic receive_enable_out,
  output logic collision_out,
  output logic link_loss_indicator,
  output logic tp_transmit_pos,
  output logic tp_transmit_neg,
  output logic aui_transmit_pair_pos,
  output logic aui_transmit_pair_neg
);
  localparam tal_lc_t LOSS_L = tal_lc_t'(LOSS_CYC - 1);
  localparam tal_lc_t SEP_MIN_L = tal_lc_t'(SEP_MIN_CYC);
  localparam tal_lc_t SEP_MAX_L = tal_lc_t'(SEP_MAX_CYC);
  localparam tal_lc_t LP_PER_L = tal_lc_t'(LP_PER_CYC);
  localparam tal_sc_t LOCK_L = tal_sc_t'(LOCK_BITS);

  function automatic tal_sc_t inc5(input tal_sc_t c);
    return (c == 5'h1F) ? c : c + 5'h1;
  endfunction

  function automatic tal_sc_t wid5(input tal_sc_t c, input logic lvl);
    return lvl ? inc5(c) : 5'h0;
  endfunction

  function automatic tal_lc_t inc24(input tal_lc_t c);
    return (c == {CNT_W{1'b1}}) ? c : c + tal_lc_t'(1);
  endfunction

  // pin synchronisers; s3 only gives edges of s2
  logic [8:0] s1_r, s2_r, s3_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 9'h000;
      s2_r <= 9'h000;
      s3_r <= 9'h000;
    end else begin
      s1_r <= {aui_collision_pair_neg, aui_collision_pair_pos, aui_receive_pair_neg,
               aui_receive_pair_pos, tp_receive_pair_neg, tp_receive_pair_pos,
               full_duplex_select, transmit_enable_in, tx_data_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic txd, ten, fd, tpp, tpn, arp, arn, acp, acn, tp_any;
  assign {acn, acp, arn, arp, tpn, tpp, fd, ten, txd} = s2_r;
  assign tp_any = tpp | tpn;

  logic aui_sel_r;
  logic aw_h_r, w_h_r;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  assign wr_go = aw_h_r & w_h_r & ~s_axi_bvalid;

  // axi write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_r <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end else if (!aw_h_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_r <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_h_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // port select: 1 = aui, 0 = twisted pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aui_sel_r <= CTRL_RST;
    end else if (wr_go && awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
      aui_sel_r <= wdata_q[CTRL_AUI_BIT];
    end
  end

  logic tp_car_r, aui_sq_open_r;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == ADDR_CTRL) begin
      w[CTRL_AUI_BIT] = aui_sel_r;
    end else if (a == ADDR_STAT) begin
      w[4:0] = {collision_out, receive_enable_out, aui_sq_open_r, tp_car_r, link_loss_indicator};
    end
    return w;
  endfunction

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word({s_axi_araddr[7:2], 2'h0});
      s_axi_rresp <= ({s_axi_araddr[7:2], 2'h0} == ADDR_CTRL ||
                      {s_axi_araddr[7:2], 2'h0} == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  tal_sc_t ph_r;
  logic txbit_r, tx_act_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_r <= 5'h0;
      txbit_r <= 1'b0;
      tx_act_r <= 1'b0;
      transmit_bit_clock <= 1'b0;
    end else begin
      ph_r <= (ph_r == BIT_LAST) ? 5'h0 : ph_r + 5'h1;
      transmit_bit_clock <= (ph_r < HALF_CYC);
      if (ph_r == BIT_LAST) begin
        txbit_r <= txd;
        tx_act_r <= ten;
      end
    end
  end

  // idle, end hold and link pulse sequencing
  tal_tx_t st_r;
  tal_sc_t hc_r;
  tal_lc_t lp_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= TX_IDLE;
      hc_r <= 5'h0;
      lp_r <= '0;
    end else begin
      hc_r <= inc5(hc_r);
      lp_r <= (st_r == TX_IDLE) ? inc24(lp_r) : '0;
      unique case (st_r)
        TX_IDLE: begin
          if (tx_act_r) begin
            st_r <= TX_DATA;
          end else if (lp_r >= LP_PER_L) begin
            st_r <= TX_LP;
            hc_r <= 5'h0;
          end
        end
        TX_DATA: begin
          if (!tx_act_r) begin
            st_r <= TX_EOF;
            hc_r <= 5'h0;
          end
        end
        TX_EOF: begin
          if (tx_act_r) begin
            st_r <= TX_DATA;
          end else if (hc_r == AUI_HOLD_CYC - 5'h1) begin
            st_r <= TX_IDLE;
          end
        end
        TX_LP: begin
          if (hc_r == LP_W_CYC - 5'h1) begin
            st_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // manchester: first half inverted, second half true
  logic manch;
  assign manch = (ph_r < HALF_CYC) ? ~txbit_r : txbit_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tp_transmit_pos <= 1'b0;
      tp_transmit_neg <= 1'b0;
      aui_transmit_pair_pos <= 1'b0;
      aui_transmit_pair_neg <= 1'b0;
    end else begin
      tp_transmit_pos <= (st_r == TX_DATA && !aui_sel_r) ? manch :
                         (st_r == TX_LP || (st_r == TX_EOF && !aui_sel_r));
      tp_transmit_neg <= (st_r == TX_DATA && !aui_sel_r) & ~manch;
      // aui cells and positive end hold
      aui_transmit_pair_pos <= (st_r == TX_DATA && aui_sel_r) ? manch : (st_r == TX_EOF && aui_sel_r);
      aui_transmit_pair_neg <= (st_r == TX_DATA && aui_sel_r) & ~manch;
    end
  end

  tal_sc_t gap_r, pw_r;
  logic [2:0] qual_r;
  logic tp_edge;
  assign tp_edge = tpp ^ s3_r[3];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 5'h1F;
      qual_r <= 3'h0;
      tp_car_r <= 1'b0;
    end else begin
      gap_r <= tp_edge ? 5'h0 : inc5(gap_r);
      if (tp_edge) begin
        if (gap_r >= 5'h1 && gap_r <= TP_GAP_CYC) begin
          qual_r <= (qual_r == QUAL_EDGES) ? qual_r : qual_r + 3'h1;
          if (qual_r >= QUAL_EDGES - 3'h1) begin
            tp_car_r <= 1'b1;
          end
        end else begin
          qual_r <= 3'h0;
        end
      end else if (gap_r == TP_EOF_CYC) begin
        qual_r <= 3'h0;
        tp_car_r <= 1'b0;
      end
    end
  end

  logic lp_seen;
  assign lp_seen = s3_r[3] & ~tpp & ~tp_car_r & (pw_r >= LPW_MIN_CYC) & (pw_r <= LPW_MAX_CYC);
  tal_lc_t sep_r, loss_r;
  logic beat_ok;
  assign beat_ok = lp_seen & (sep_r >= SEP_MIN_L) & (sep_r <= SEP_MAX_L);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_r <= 5'h0;
      sep_r <= '0;
      loss_r <= '0;
      link_loss_indicator <= 1'b1;
    end else begin
      pw_r <= wid5(pw_r, tpp);
      if (lp_seen && sep_r >= SEP_MIN_L) begin
        sep_r <= '0;
      end else begin
        sep_r <= inc24(sep_r);
      end
      if (tp_any) begin
        loss_r <= '0;
      end else if (loss_r != LOSS_L) begin
        loss_r <= loss_r + tal_lc_t'(1);
      end
      if (loss_r == LOSS_L && !tp_any) begin
        link_loss_indicator <= 1'b1;
      end else if (beat_ok) begin
        link_loss_indicator <= 1'b0;
      end
    end
  end

  tal_sc_t nwa_r, nwc_r, pwa_r, pwc_r, aid_r;
  logic negv_a, negv_c, pend_a, pend_c, a_idle, cx_act_r;
  assign negv_a = arn & (nwa_r == AUI_VAL_CYC - 5'h1);
  assign negv_c = acn & (nwc_r == AUI_VAL_CYC - 5'h1);
  assign pend_a = arp & (pwa_r == AUI_EOF_CYC - 5'h1);
  assign pend_c = acp & (pwc_r == AUI_EOF_CYC - 5'h1);
  assign a_idle = (aid_r == AUI_EOF_CYC - 5'h1) & ~(arp | arn | acp | acn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nwa_r <= 5'h0;
      nwc_r <= 5'h0;
      pwa_r <= 5'h0;
      pwc_r <= 5'h0;
      aid_r <= 5'h0;
    end else begin
      nwa_r <= wid5(nwa_r, arn);
      nwc_r <= wid5(nwc_r, acn);
      pwa_r <= wid5(pwa_r, arp);
      pwc_r <= wid5(pwc_r, acp);
      aid_r <= wid5(aid_r, ~(arp | arn | acp | acn));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aui_sq_open_r <= 1'b0;
      cx_act_r <= 1'b0;
    end else begin
      if (negv_a || negv_c) begin
        aui_sq_open_r <= 1'b1;
      end else if (pend_a || pend_c || a_idle) begin
        aui_sq_open_r <= 1'b0;
      end
      if (negv_c) begin
        cx_act_r <= 1'b1;
      end else if (pend_c || a_idle) begin
        cx_act_r <= 1'b0;
      end
    end
  end

  // shared manchester decoder on the selected receive line
  logic line, line_e, lb;
  tal_sc_t mid_r, bits_r;
  logic lock;
  assign line = aui_sel_r ? arp : tpp;
  assign line_e = aui_sel_r ? (arp ^ s3_r[5]) : tp_edge;
  assign lb = ten & ~fd & ~aui_sel_r;
  assign lock = aui_sel_r ? aui_sq_open_r : (tp_car_r & (bits_r >= LOCK_L));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mid_r <= 5'h1F;
      bits_r <= 5'h0;
    end else begin
      if (line_e && mid_r >= MID_CYC - 5'h1) begin
        mid_r <= 5'h0;
      end else begin
        mid_r <= inc5(mid_r);
      end
      if (!(aui_sel_r ? aui_sq_open_r : tp_car_r)) begin
        bits_r <= 5'h0;
      end else if (line_e && mid_r >= MID_CYC - 5'h1) begin
        bits_r <= inc5(bits_r);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_out <= 1'b0;
      rx_clock_out <= 1'b0;
      receive_enable_out <= 1'b0;
    end else begin
      receive_enable_out <= lb | lock;
      if (lb) begin
        rx_data_out <= txbit_r;
        rx_clock_out <= transmit_bit_clock;
      end else if (lock && line_e && mid_r >= MID_CYC - 5'h1) begin
        rx_data_out <= line;
        rx_clock_out <= 1'b0;
      end else if (mid_r == HALF_CYC) begin
        rx_clock_out <= 1'b1;
      end
    end
  end

  logic col_tp;
  tal_sc_t hold_r;
  assign col_tp = tp_car_r & ten & ~fd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      collision_out <= 1'b0;
      hold_r <= 5'h0;
    end else if (fd) begin
      collision_out <= 1'b0;
      hold_r <= 5'h0;
    end else if (aui_sel_r) begin
      collision_out <= cx_act_r;
      hold_r <= 5'h0;
    end else if (col_tp) begin
      collision_out <= 1'b1;
      hold_r <= COL_OFF_CYC;
    end else if (collision_out && tp_car_r && hold_r != 5'h0) begin
      hold_r <= hold_r - 5'h1;
    end else begin
      collision_out <= 1'b0;
      hold_r <= 5'h0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  loss_set_a: assert property ((loss_r == LOSS_L && !tp_any) |=> link_loss_indicator)
    else $error("link loss not raised at timeout");
  beat_width_a: assert property ($fell(link_loss_indicator) |->
    ($past(pw_r) >= LPW_MIN_CYC && $past(pw_r) <= LPW_MAX_CYC))
    else $error("link restored by bad width pulse");
  beat_sep_a: assert property ($fell(link_loss_indicator) |->
    ($past(lp_seen) && $past(sep_r) >= SEP_MIN_L && $past(sep_r) <= SEP_MAX_L))
    else $error("link restored without consecutive beat");
  col_on_a: assert property ((col_tp && !aui_sel_r) |=> collision_out)
    else $error("collision not raised");
  col_hold_a: assert property (($fell(ten) && collision_out && !fd && !aui_sel_r) |=>
    (collision_out || !tp_car_r || fd)[*8])
    else $error("collision dropped early");
  fd_col_a: assert property (fd |=> !collision_out)
    else $error("collision in full duplex");
  lb_receive_enable_out_a: assert property ((ten && !fd && !aui_sel_r) |=> receive_enable_out)
    else $error("loopback receive enable missing");
  aui_hold_a: assert property ((st_r == TX_DATA && !tx_act_r && aui_sel_r) |->
    ##2 (aui_transmit_pair_pos || tx_act_r)[*8])
    else $error("aui end hold too short");
  manch_half_a: assert property ((st_r == TX_DATA && ph_r == 5'h3 && !aui_sel_r) |->
    (tp_transmit_pos == txbit_r && tp_transmit_neg == !txbit_r))
    else $error("manchester second half wrong");
  sq_open_a: assert property ($rose(aui_sq_open_r) |-> $past(negv_a || negv_c))
    else $error("squelch opened without valid pulse");
  sq_eof_a: assert property ((pend_a && !negv_a && !negv_c) |=> !aui_sq_open_r)
    else $error("squelch not re-engaged");
  b_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");
endmodule
`default_nettype wire

// ### design/tal_pkg.sv
package tal_pkg;
  typedef logic [4:0] tal_sc_t;
  localparam int unsigned CNT_W = 24;
  typedef logic [CNT_W-1:0] tal_lc_t;
  typedef enum {TX_IDLE, TX_DATA, TX_EOF, TX_LP} tal_tx_t;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned BIT_NS = 100;
  localparam tal_sc_t BIT_LAST = tal_sc_t'(BIT_NS / CLK_NS - 1);
  localparam tal_sc_t HALF_CYC = tal_sc_t'(BIT_NS / CLK_NS / 2);
  localparam int unsigned LPW_MIN_NS = 50;
  localparam tal_sc_t LPW_MIN_CYC = tal_sc_t'((LPW_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned LPW_MAX_NS = 200;
  localparam tal_sc_t LPW_MAX_CYC = tal_sc_t'(LPW_MAX_NS / CLK_NS);
  localparam int unsigned LOSS_MS = 100;
  localparam int unsigned SEP_MIN_US = 3000;
  localparam int unsigned SEP_MAX_MS = 100;
  localparam int unsigned LP_PER_MS = 16;
  localparam int unsigned LP_W_NS = 100;
  localparam tal_sc_t LP_W_CYC = tal_sc_t'(LP_W_NS / CLK_NS);
  localparam int unsigned COL_OFF_NS = 350;
  localparam tal_sc_t COL_OFF_CYC = tal_sc_t'((COL_OFF_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned AUI_HOLD_NS = 200;
  localparam tal_sc_t AUI_HOLD_CYC = tal_sc_t'((AUI_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned AUI_VAL_NS = 25;
  localparam tal_sc_t AUI_VAL_CYC = tal_sc_t'(AUI_VAL_NS / CLK_NS + 1);
  localparam int unsigned AUI_EOF_NS = 175;
  localparam tal_sc_t AUI_EOF_CYC = tal_sc_t'(AUI_EOF_NS / CLK_NS + 1);
  localparam int unsigned TP_EOF_NS = 230;
  localparam tal_sc_t TP_EOF_CYC = tal_sc_t'((TP_EOF_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned TP_GAP_NS = 200;
  localparam tal_sc_t TP_GAP_CYC = tal_sc_t'(TP_GAP_NS / CLK_NS);
  localparam int unsigned MID_NS = 75;
  localparam tal_sc_t MID_CYC = tal_sc_t'((MID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] QUAL_EDGES = 3'h4;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned CTRL_AUI_BIT = 0;
  localparam logic CTRL_RST = 1'h0;
endpackage

// ### tb/tal_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module tal_ctrl_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic transmit_bit_clock,
  input wire logic receive_enable_out,
  input wire logic go,
  input wire logic overlap,
  input wire logic [7:0] nbits,
  output logic tx_data_in,
  output logic transmit_enable_in,
  output logic busy
);
  logic tbc_r;
  logic [7:0] left_r;
  always_ff @(posedge aclk) begin
    tbc_r <= transmit_bit_clock;
    if (!aresetn) begin
      busy <= 1'h0;
      transmit_enable_in <= 1'h0;
      tx_data_in <= 1'h0;
      left_r <= 8'h00;
    end else if (!busy) begin
      // idle data line keeps changing
      tx_data_in <= ~tx_data_in;
      if (go && (overlap || !receive_enable_out)) begin
        busy <= 1'h1;
        left_r <= nbits;
      end
    end else if (tbc_r && !transmit_bit_clock) begin
      transmit_enable_in <= (left_r != 8'h00);
      tx_data_in <= 1'h1;
      busy <= (left_r != 8'h00);
      left_r <= left_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tal_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, nbits;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, ar2, ac2, cr_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_data_in, transmit_enable_in;
  logic full_duplex_select, tp_receive_pair_pos, tp_receive_pair_neg, transmit_bit_clock, rx_data_out, rx_clock_out;
  logic receive_enable_out, collision_out, link_loss_indicator, tp_transmit_pos, tp_transmit_neg;
  logic aui_transmit_pair_pos, aui_transmit_pair_neg, go, overlap, busy, cr_on, en_q, col_q, tbc_q, tp_q, au_q;
  logic rxc_q, tn_q;
  int n_mismatch, samples_checked, cyc, n_re, n_rx1, n_col, n_tbc, n_tp, n_au, run, last_run, t_enr, t_enf, t_clr, t_clf;
  int s1, s2, s3, s4, s5, n_rxc, n_tn;
  tal_phy #(.LOSS_CYC(2000), .SEP_MIN_CYC(100), .SEP_MAX_CYC(1500), .LP_PER_CYC(300)) u_tal_phy (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data_in, .transmit_enable_in, .full_duplex_select,
    .tp_receive_pair_pos, .tp_receive_pair_neg, .aui_receive_pair_pos(ar2[1]), .aui_receive_pair_neg(ar2[0]),
    .aui_collision_pair_pos(ac2[1]), .aui_collision_pair_neg(ac2[0]), .transmit_bit_clock, .rx_data_out,
    .rx_clock_out, .receive_enable_out, .collision_out, .link_loss_indicator, .tp_transmit_pos, .tp_transmit_neg,
    .aui_transmit_pair_pos, .aui_transmit_pair_neg);
  tal_ctrl_model u_tal_ctrl_model (.aclk, .aresetn, .transmit_bit_clock, .receive_enable_out, .go, .overlap,
    .nbits, .tx_data_in, .transmit_enable_in, .busy);
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  // far-end carrier, 160 ns period
  always @(posedge aclk) begin
    if (cr_on) begin
      cr_n <= cr_n + 2'h1;
      if (cr_n == 2'h3) begin
        tp_receive_pair_pos <= ~tp_receive_pair_pos;
        tp_receive_pair_neg <= tp_receive_pair_pos;
      end
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    en_q <= transmit_enable_in;
    col_q <= collision_out;
    tbc_q <= transmit_bit_clock;
    tp_q <= tp_transmit_pos;
    au_q <= aui_transmit_pair_pos;
    rxc_q <= rx_clock_out;
    tn_q <= tp_transmit_neg;
    n_rxc <= n_rxc + int'(rx_clock_out === 1'h1 && rxc_q === 1'h0);
    n_tn <= n_tn + int'(tp_transmit_neg === 1'h1 && tn_q === 1'h0);
    n_re <= n_re + int'(receive_enable_out === 1'h1);
    n_rx1 <= n_rx1 + int'(receive_enable_out === 1'h1 && rx_data_out === 1'h1);
    n_col <= n_col + int'(collision_out === 1'h1);
    n_tbc <= n_tbc + int'(transmit_bit_clock === 1'h1 && tbc_q === 1'h0);
    n_tp <= n_tp + int'(tp_transmit_pos === 1'h1 && tp_q === 1'h0);
    n_au <= n_au + int'(aui_transmit_pair_pos === 1'h1 && au_q === 1'h0);
    run <= (aui_transmit_pair_pos === 1'h1 && aui_transmit_pair_neg === 1'h0) ? run + 1 : 0;
    if (run > 0 && aui_transmit_pair_pos !== 1'h1) last_run <= run;
    if (transmit_enable_in === 1'h1 && en_q === 1'h0) t_enr <= cyc;
    if (transmit_enable_in === 1'h0 && en_q === 1'h1) t_enf <= cyc;
    if (collision_out === 1'h1 && col_q === 1'h0) t_clr <= cyc;
    if (collision_out === 1'h0 && col_q === 1'h1) t_clf <= cyc;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task lp(input int w, input int g);
    @(posedge aclk);
    tp_receive_pair_pos <= 1'h1;
    repeat (w) @(posedge aclk);
    tp_receive_pair_pos <= 1'h0;
    repeat (g) @(posedge aclk);
  endtask
  task tx(input logic [7:0] n, input logic ov);
    int k;
    k = 0;
    @(posedge aclk);
    nbits <= n;
    overlap <= ov;
    go <= 1'h1;
    do begin @(posedge aclk); k++; end while (busy !== 1'h1 && k < 100);
    go <= 1'h0;
    do begin @(posedge aclk); k++; end while (busy === 1'h1 && k < 2000);
    repeat (40) @(posedge aclk);
    chk(32'(busy), 32'h0);
  endtask
  // np must be at least 1
  task aup(input logic col, input int nn, input int np, input int reps);
    @(posedge aclk);
    repeat (reps) begin
      if (nn > 0) begin
        if (col) ac2 <= 2'h1; else ar2 <= 2'h1;
        repeat (nn) @(posedge aclk);
      end
      if (col) ac2 <= 2'h2; else ar2 <= 2'h2;
      repeat (np) @(posedge aclk);
    end
    ac2 <= 2'h0;
    ar2 <= 2'h0;
  endtask
  task t_regs;
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_STAT, 32'h1, RESP_OKAY);
    axw(ADDR_STAT, 32'h1, RESP_SLVERR);
    axr(8'h10, 32'h0, RESP_SLVERR);
  endtask
  task t_link;
    repeat (3) lp(1, 400);
    chk(32'(link_loss_indicator), 32'h1);
    repeat (3) lp(5, 2000);
    chk(32'(link_loss_indicator), 32'h1);
    repeat (3) lp(5, 25);
    chk(32'(link_loss_indicator), 32'h1);
    repeat (300) @(posedge aclk);
    lp(5, 20);
    chk(32'(link_loss_indicator), 32'h0);
    s1 = n_tp;
    repeat (1800) @(posedge aclk);
    chk(32'(link_loss_indicator), 32'h0);
    repeat (400) @(posedge aclk);
    chk(32'(link_loss_indicator), 32'h1);
    chk(32'(n_tp - s1 >= 5), 32'h1);
  endtask
  task t_tx_tp;
    s1 = n_au;
    s2 = n_tp;
    s3 = n_rx1;
    s4 = n_rxc;
    s5 = n_tn;
    tx(8'h28, 1'h0);
    chk(32'(n_au - s1), 32'h0);
    chk(32'(n_tn - s5 >= 20), 32'h1);
    chk(32'(n_rxc - s4 >= 35), 32'h1);
    chk(32'(n_tp - s2 >= 40), 32'h1);
    chk(32'(n_rx1 - s3 >= 150), 32'h1);
    full_duplex_select <= 1'h1;
    repeat (10) @(posedge aclk);
    s1 = n_re;
    tx(8'h28, 1'h0);
    chk(32'(n_re - s1), 32'h0);
    full_duplex_select <= 1'h0;
    s1 = n_tbc;
    repeat (100) @(posedge aclk);
    chk(32'(n_tbc - s1), 32'h14);
  endtask
  task t_col;
    cr_on <= 1'h1;
    repeat (80) @(posedge aclk);
    chk(32'(receive_enable_out), 32'h1);
    tx(8'h3C, 1'h1);
    chk(32'(t_clr - t_enr <= 15), 32'h1);
    chk(32'(t_clf - t_enf >= 18 && t_clf - t_enf <= 45), 32'h1);
    full_duplex_select <= 1'h1;
    repeat (10) @(posedge aclk);
    s1 = n_col;
    tx(8'h3C, 1'h1);
    chk(32'(n_col - s1), 32'h0);
    full_duplex_select <= 1'h0;
    cr_on <= 1'h0;
    @(posedge aclk);
    tp_receive_pair_pos <= 1'h0;
    tp_receive_pair_neg <= 1'h0;
    repeat (40) @(posedge aclk);
  endtask
  task t_aui;
    axw(ADDR_CTRL, 32'h1, RESP_OKAY);
    s1 = n_au;
    tx(8'h28, 1'h0);
    chk(32'(n_au - s1 >= 40), 32'h1);
    chk(32'(last_run >= 10), 32'h1);
    s1 = n_re;
    aup(1'h0, 1, 1, 1);
    repeat (15) @(posedge aclk);
    chk(32'(n_re - s1), 32'h0);
    aup(1'h0, 3, 3, 8);
    chk(32'(n_re - s1 > 0), 32'h1);
    aup(1'h0, 0, 30, 1);
    chk(32'(receive_enable_out), 32'h0);
    s1 = n_col;
    aup(1'h1, 3, 3, 6);
    chk(32'(n_col - s1 > 0), 32'h1);
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, nbits, s_axi_wdata} = 56'h0;
    {s_axi_wstrb, ar2, ac2, cr_n} = 10'h3C0;
    {full_duplex_select, tp_receive_pair_pos, tp_receive_pair_neg, go, overlap, cr_on} = 6'h00;
    {n_mismatch, samples_checked, cyc, n_re, n_rx1, n_col, n_tbc, n_tp, n_au, run, last_run} = '0;
    {t_enr, t_enf, t_clr, t_clf, n_rxc, n_tn} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    t_regs();
    t_link();
    t_tx_tp();
    t_col();
    t_aui();
    print_verdict();
  end
endmodule
`default_nettype wire
